// >>> rtl/uafc_pkg.sv
// package: constants and types for the usb audio feature control block
package uafc_pkg;
  // configuration map layout
  localparam int MAP_COUNT = 4;
  localparam int MAP_SEL_W = 2;
  localparam int MAP_WORD_W = 16;
  // alternate settings
  localparam int ALT_COUNT = 7;
  localparam logic [2:0] ALT_ZERO_BW = 3'h0;
  localparam logic [2:0] ALT_MAX = 3'h6;
  localparam int SAMPLES_PER_MS_MAX = 56;
  localparam logic [8:0] ISO_BUF_BYTES = 9'h150;
  // sampling frequency bounds in hz
  localparam logic [15:0] FS_MIN_HZ = 16'h1388;
  localparam logic [15:0] FS_MAX_HZ = 16'hd6d8;
  // hid and control endpoint limits
  localparam logic [6:0] HID_MAX_BYTES = 7'h40;
  localparam logic [3:0] CTRL_MAX_BYTES = 4'h8;
  localparam logic [3:0] EP_CONTROL = 4'h0;
  localparam logic [3:0] EP_STATUS = 4'h3;
  localparam logic [1:0] HID_ITEM_BASIC = 2'h0;
  localparam int BUTTON_COUNT = 3;
  localparam int LAMP_COUNT = 2;
  // hid poll spacing: 1 ms at 200 MHz
  localparam int POLL_MS = 1;
  localparam int CLK_MHZ = 200;
  localparam int POLL_CYCLES = POLL_MS * CLK_MHZ * 1000;
  // volume in whole db of attenuation
  localparam logic [6:0] VOL_MIN_DB = 7'h3c;
  localparam logic [6:0] VOL_MUTED = 7'h7f;
  // feature selectors
  localparam logic [2:0] FEAT_VOL_L = 3'h0;
  localparam logic [2:0] FEAT_VOL_R = 3'h1;
  localparam logic [2:0] FEAT_MUTE = 3'h2;
  localparam logic [2:0] FEAT_TREBLE = 3'h3;
  localparam logic [2:0] FEAT_BASS = 3'h4;
  localparam logic [2:0] FEAT_BOOST = 3'h5;
  // entity targets of a class request
  localparam logic [1:0] ENT_FEATURE = 2'h0;
  localparam logic [1:0] ENT_SOURCE = 2'h1;
  localparam logic [1:0] ENT_SINK = 2'h2;
  // start-up sequencer
  typedef enum logic [3:0] {
    UAFC_ST_RESET = 4'b0001,
    UAFC_ST_STRAP = 4'b0010,
    UAFC_ST_WAIT  = 4'b0100,
    UAFC_ST_RUN   = 4'b1000
  } uafc_state_e;
endpackage : uafc_pkg

// >>> rtl/uafc_map_rom.sv
// built-in configuration maps with registered read data
`timescale 1ns/1ps
module uafc_map_rom
  import uafc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_sel,
  output logic [15:0] o_word
);
  // word: [15:9] zero, [8:2] start volume in db down, [1:0] tone mode
  logic [15:0] rom_reg;
  logic [15:0] rom_next;

  // fixed table, one word per map
  always_comb begin
    case (i_sel)
      2'h0: rom_next = 16'h0001;
      2'h1: rom_next = 16'h0029;
      2'h2: rom_next = 16'h0052;
      default: rom_next = 16'h0078;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rom_reg <= 16'h0000;
    end else begin
      rom_reg <= rom_next;
    end
  end

  assign o_word = rom_reg;
endmodule : uafc_map_rom

// >>> rtl/uafc_vol_decode.sv
// decodes a host volume word into a clamped attenuation in db
`timescale 1ns/1ps
module uafc_vol_decode
  import uafc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_wvol,
  output logic [6:0] o_atten
);
  logic [6:0] att_reg;
  logic [6:0] att_next;
  logic [7:0] hi;
  logic [7:0] mag;

  // low byte is dropped, high byte is signed whole db
  always_comb begin
    hi = i_wvol[15:8]; // RULE16
    mag = 8'h00 - hi; // RULE25
    if (!hi[7]) begin
      att_next = 7'h00; // RULE17
    end else if (hi == 8'h80 || mag > {1'b0, VOL_MIN_DB}) begin
      att_next = VOL_MUTED; // RULE24
    end else begin
      att_next = mag[6:0]; // RULE15
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      att_reg <= 7'h00;
    end else begin
      att_reg <= att_next;
    end
  end

  assign o_atten = att_reg;
endmodule : uafc_vol_decode

// >>> rtl/uafc_top.sv
// feature control core of a usb audio sink: config maps, alt settings, hid, features
//
// Function
// (RULE1) at start-up pick one of four built-in maps from two select pins
// (RULE2) a map loaded from external eeprom replaces the pin-selected map
// (RULE3) seven alternate settings: 8/16/24-bit mono, stereo, plus zero bandwidth
// (RULE4) max packet size is bytes per sample times channels times 56
// (RULE5) sink buffer stores at most 336 bytes per frame
// (RULE6) sink is isochronous adaptive, accepts 5 to 55 khz continuous rate
// (RULE7) answer hid get-report and set-report on control endpoint 0
// (RULE8) hid interrupt data at most 64 bytes, polled at most every 1 ms
// (RULE9) report items use a one-byte prefix, short basic items only
// (RULE10) input reports go on endpoint 3, both reports also on endpoint 0
// (RULE11) up to three buttons, on while pressed, off when released
// (RULE12) up to two host-driven outputs from output report data
// (RULE13) volume per left and right; mute, tone, boost master only
// (RULE14) features change by host requests or assigned button presses
// (RULE15) volume spans 0 to -60 db in 1 db steps plus muted
// (RULE16) low byte of the host volume word is ignored
// (RULE17) volume above 0 db clamps to 0 db and reads back 0 db
// (RULE18) 0 db is maximum output, other steps attenuate from it
// (RULE19) volumes start from the value in the selected map
// (RULE20) balance comes only from separate left and right volumes
// (RULE21) configuration descriptor request returns all but device descriptor
// (RULE22) terminals accept no control; only the feature unit is controllable
// (RULE23) control endpoint packets carry at most 8 bytes
// (RULE24) volume codes from -61 db down drive full mute
// (RULE25) volume high byte is two's complement whole decibels
`timescale 1ns/1ps
module uafc_top
  import uafc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_config_select_hi,
  input wire logic i_config_select_lo,
  input wire logic i_eeprom_valid,
  input wire logic [15:0] i_eeprom_word,
  input wire logic i_alt_wr,
  input wire logic [2:0] i_alt_setting,
  input wire logic i_iso_byte,
  input wire logic i_sof,
  input wire logic [23:0] i_fs_hz,
  input wire logic i_feat_wr,
  input wire logic [1:0] i_feat_entity,
  input wire logic [2:0] i_feat_sel,
  input wire logic [15:0] i_feat_data,
  input wire logic i_report_get,
  input wire logic i_report_set,
  input wire logic [3:0] i_report_ep,
  input wire logic [1:0] i_report_out,
  input wire logic i_ctrl_byte,
  input wire logic i_ctrl_pkt_end,
  input wire logic i_desc_cfg_get,
  input wire logic [2:0] i_button,
  input wire logic [1:0] i_button_role,
  output logic o_ready,
  output logic [1:0] o_map_sel,
  output logic [1:0] o_tone_mode,
  output logic [8:0] o_max_packet,
  output logic o_iso_accept,
  output logic o_fs_ok,
  output logic o_report_valid,
  output logic [3:0] o_report_ep,
  output logic [7:0] o_report_data,
  output logic [7:0] o_item_prefix,
  output logic o_ctrl_stall,
  output logic o_desc_skip_device,
  output logic o_req_stall,
  output logic [1:0] o_lamp,
  output logic [6:0] o_vol_l,
  output logic [6:0] o_vol_r,
  output logic o_mute,
  output logic [7:0] o_treble,
  output logic [7:0] o_bass,
  output logic o_boost
);
  uafc_state_e st_reg, st_next;
  logic [1:0] sel_reg, sel_next, lamp_reg, lamp_next, vol_pend_reg, vol_pend_next;
  logic [15:0] map_reg, map_next, rom_word;
  logic [2:0] alt_reg, alt_next, btn_prev_reg, btn_rise;
  logic [8:0] pkt_reg, pkt_next, cnt_reg, cnt_next;
  logic [6:0] atten, vl_reg, vl_next, vr_reg, vr_next;
  logic [7:0] treb_reg, treb_next, bass_reg, bass_next, rd_reg, rd_next;
  logic [3:0] rep_reg, rep_next, cb_reg, cb_next;
  logic [17:0] poll_reg, poll_next;
  logic acc_reg, acc_next, fs_reg, fs_next, mute_reg, mute_next, boost_reg, boost_next;
  logic rv_reg, rv_next, pend_reg, pend_next, cst_reg, cst_next, dsk_reg, dsk_next;
  logic rst_stall_reg, rst_stall_next, vol_upd_l, vol_upd_r;
  uafc_map_rom u_rom (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_sel(sel_next),
    .o_word(rom_word)
  );
  uafc_vol_decode u_vol (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wvol(i_feat_data),
    .o_atten(atten)
  );
  // start-up: strap sample, rom read, then optional eeprom overwrite
  always_comb begin
    st_next = st_reg;
    sel_next = sel_reg;
    map_next = map_reg;
    case (st_reg)
      UAFC_ST_RESET: st_next = UAFC_ST_STRAP;
      UAFC_ST_STRAP: begin
        sel_next = {i_config_select_hi, i_config_select_lo}; // RULE1
        st_next = UAFC_ST_WAIT;
      end
      UAFC_ST_WAIT: st_next = UAFC_ST_RUN; // rom data lands one cycle after select
      UAFC_ST_RUN: if (i_eeprom_valid) map_next = i_eeprom_word; // RULE2
      default: st_next = UAFC_ST_RESET;
    endcase
    if (st_reg == UAFC_ST_WAIT) begin
      map_next = rom_word; // RULE1
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= UAFC_ST_RESET;
      sel_reg <= 2'h0;
      map_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      sel_reg <= sel_next;
      map_reg <= map_next;
    end
  end
  // alternate setting and isochronous budget per 1 ms frame
  always_comb begin
    logic [1:0] bps;
    logic [1:0] ch;
    bps = 2'h0;
    ch = 2'h0;
    alt_next = alt_reg;
    if (i_alt_wr && i_alt_setting <= ALT_MAX) begin
      alt_next = i_alt_setting; // RULE3
    end
    // settings 1..6: 8m,8s,16m,16s,24m,24s
    if (alt_reg != ALT_ZERO_BW) begin
      bps = 2'((alt_reg - 3'h1) >> 1) + 2'h1;
      ch = {1'b0, ~alt_reg[0]} + 2'h1;
    end
    pkt_next = 9'(bps * ch * SAMPLES_PER_MS_MAX); // RULE4
    fs_next = (i_fs_hz >= {8'h00, FS_MIN_HZ}) && (i_fs_hz <= {8'h00, FS_MAX_HZ}); // RULE6
    cnt_next = i_sof ? 9'h000 : cnt_reg;
    acc_next = 1'b0;
    if (i_iso_byte && !i_sof && fs_reg && cnt_reg < pkt_reg && cnt_reg < ISO_BUF_BYTES) begin
      cnt_next = cnt_reg + 9'h001; // RULE5
      acc_next = 1'b1; // RULE6
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_reg <= ALT_ZERO_BW;
      pkt_reg <= 9'h000;
      cnt_reg <= 9'h000;
      acc_reg <= 1'b0;
      fs_reg <= 1'b0;
    end else begin
      alt_reg <= alt_next;
      pkt_reg <= pkt_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      fs_reg <= fs_next;
    end
  end
  // host feature writes: feature unit only, terminals stall
  assign vol_upd_l = i_feat_wr && i_feat_entity == ENT_FEATURE && i_feat_sel == FEAT_VOL_L;
  assign vol_upd_r = i_feat_wr && i_feat_entity == ENT_FEATURE && i_feat_sel == FEAT_VOL_R;
  assign btn_rise = i_button & ~btn_prev_reg;
  always_comb begin
    vl_next = vl_reg;
    vr_next = vr_reg;
    mute_next = mute_reg;
    treb_next = treb_reg;
    bass_next = bass_reg;
    boost_next = boost_reg;
    rst_stall_next = 1'b0;
    // decoder output is one cycle late, so apply on the following cycle
    vol_pend_next = {vol_upd_r, vol_upd_l};
    if (st_reg == UAFC_ST_WAIT || (st_reg == UAFC_ST_RUN && i_eeprom_valid)) begin
      vl_next = st_reg == UAFC_ST_WAIT ? rom_word[8:2] : i_eeprom_word[8:2]; // RULE19
      vr_next = vl_next; // RULE19
    end
    if (vol_pend_reg[0]) vl_next = atten; // RULE13 RULE20
    if (vol_pend_reg[1]) vr_next = atten; // RULE13 RULE20
    if (i_feat_wr) begin
      if (i_feat_entity != ENT_FEATURE) begin
        rst_stall_next = 1'b1; // RULE22
      end else begin
        case (i_feat_sel)
          FEAT_MUTE: mute_next = i_feat_data[0]; // RULE13
          FEAT_TREBLE: treb_next = i_feat_data[7] ? 8'h00 : i_feat_data[7:0]; // RULE13
          FEAT_BASS: bass_next = i_feat_data[7] ? 8'h00 : i_feat_data[7:0]; // RULE13
          FEAT_BOOST: boost_next = i_feat_data[0]; // RULE13
          FEAT_VOL_L, FEAT_VOL_R: rst_stall_next = 1'b0;
          default: rst_stall_next = 1'b1;
        endcase
      end
    end
    // button 0 acts by role: 0 toggles mute, 1 toggles boost, 2 steps both volumes up 1 db, 3 steps them down
    if (btn_rise[0]) begin
      case (i_button_role)
        2'h0: mute_next = ~mute_reg; // RULE14
        2'h1: boost_next = ~boost_reg; // RULE14
        2'h2: begin
          vl_next = (vl_reg > VOL_MIN_DB) ? VOL_MIN_DB : vl_reg - {6'h00, |vl_reg}; // RULE14
          vr_next = (vr_reg > VOL_MIN_DB) ? VOL_MIN_DB : vr_reg - {6'h00, |vr_reg}; // RULE18
        end
        default: begin
          vl_next = (vl_reg >= VOL_MIN_DB) ? VOL_MUTED : vl_reg + 7'h01; // RULE14 RULE15
          vr_next = (vr_reg >= VOL_MIN_DB) ? VOL_MUTED : vr_reg + 7'h01; // RULE14
        end
      endcase
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vl_reg <= 7'h00;
      vr_reg <= 7'h00;
      mute_reg <= 1'b0;
      treb_reg <= 8'h00;
      bass_reg <= 8'h00;
      boost_reg <= 1'b0;
      rst_stall_reg <= 1'b0;
      vol_pend_reg <= 2'h0;
      btn_prev_reg <= 3'h0;
    end else begin
      vl_reg <= vl_next;
      vr_reg <= vr_next;
      mute_reg <= mute_next;
      treb_reg <= treb_next;
      bass_reg <= bass_next;
      boost_reg <= boost_next;
      rst_stall_reg <= rst_stall_next;
      vol_pend_reg <= vol_pend_next;
      btn_prev_reg <= i_button;
    end
  end
  // hid reports: buttons on ep 3 when changed and poll gap met, get/set on ep 0
  always_comb begin
    rv_next = 1'b0;
    rep_next = rep_reg;
    rd_next = rd_reg;
    lamp_next = lamp_reg;
    pend_next = pend_reg | (|(i_button ^ btn_prev_reg)); // set wins
    poll_next = (poll_reg != 18'h0) ? poll_reg - 18'h1 : 18'h0;
    if (i_report_set && i_report_ep == EP_CONTROL) lamp_next = i_report_out; // RULE7 RULE12
    if (i_report_get && i_report_ep == EP_CONTROL) begin
      rv_next = 1'b1; // RULE7 RULE10
      rep_next = EP_CONTROL;
      rd_next = {3'h0, lamp_reg, i_button}; // RULE10 RULE11
    end else if (pend_reg && poll_reg == 18'h0) begin
      rv_next = 1'b1; // RULE10
      rep_next = EP_STATUS;
      rd_next = {5'h00, i_button}; // RULE11
      pend_next = |(i_button ^ btn_prev_reg);
      poll_next = 18'(POLL_CYCLES - 1); // RULE8
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rv_reg <= 1'b0;
      rep_reg <= 4'h0;
      rd_reg <= 8'h00;
      lamp_reg <= 2'h0;
      pend_reg <= 1'b0;
      poll_reg <= 18'h0;
    end else begin
      rv_reg <= rv_next;
      rep_reg <= rep_next;
      rd_reg <= rd_next;
      lamp_reg <= lamp_next;
      pend_reg <= pend_next;
      poll_reg <= poll_next;
    end
  end
  // control packet byte count; a ninth byte stalls the packet
  always_comb begin
    cb_next = cb_reg;
    cst_next = cst_reg;
    dsk_next = dsk_reg;
    if (i_ctrl_pkt_end) begin
      cb_next = 4'h0;
      cst_next = 1'b0;
    end else if (i_ctrl_byte) begin
      if (cb_reg >= CTRL_MAX_BYTES) begin
        cst_next = 1'b1; // RULE23
      end else begin
        cb_next = cb_reg + 4'h1; // RULE23
      end
    end
    if (i_desc_cfg_get) dsk_next = 1'b1; // RULE21
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cb_reg <= 4'h0;
      cst_reg <= 1'b0;
      dsk_reg <= 1'b0;
    end else begin
      cb_reg <= cb_next;
      cst_reg <= cst_next;
      dsk_reg <= dsk_next;
    end
  end
  // outputs straight from flops, except the st_reg decode for o_ready and the constant item prefix
  assign o_ready = st_reg == UAFC_ST_RUN ? 1'b1 : 1'b0;
  assign o_map_sel = sel_reg;
  assign o_tone_mode = map_reg[1:0];
  assign o_max_packet = pkt_reg;
  assign o_iso_accept = acc_reg;
  assign o_fs_ok = fs_reg;
  assign o_report_valid = rv_reg;
  assign o_report_ep = rep_reg;
  assign o_report_data = rd_reg;
  assign o_item_prefix = {6'h00, HID_ITEM_BASIC}; // RULE9
  assign o_ctrl_stall = cst_reg;
  assign o_desc_skip_device = dsk_reg;
  assign o_req_stall = rst_stall_reg;
  assign o_lamp = lamp_reg;
  assign o_vol_l = vl_reg;
  assign o_vol_r = vr_reg;
  assign o_mute = mute_reg;
  assign o_treble = treb_reg;
  assign o_bass = bass_reg;
  assign o_boost = boost_reg;
endmodule : uafc_top

// >>> dv/uafc_host_model.sv
// host side model: collects hid input reports from the status pipe
`timescale 1ns/1ps
module uafc_host_model
  import uafc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_report_valid,
  input wire logic [3:0] i_report_ep,
  input wire logic [7:0] i_report_data,
  output logic [7:0] o_status_data,
  output logic [7:0] o_status_cnt
);
  // control pipe answers are left to the bench; only status pipe traffic is kept here
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status_data <= 8'h00;
      o_status_cnt <= 8'h00;
    end else if (i_report_valid && i_report_ep == EP_STATUS) begin
      o_status_data <= i_report_data;
      o_status_cnt <= o_status_cnt + 8'h01;
    end
  end
endmodule : uafc_host_model

// >>> dv/uafc_top_asserts.sv
// concurrent checks on the ports of the feature control core
`timescale 1ns/1ps
module uafc_top_asserts
  import uafc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_alt_wr,
  input wire logic [2:0] i_alt_setting,
  input wire logic i_sof,
  input wire logic [23:0] i_fs_hz,
  input wire logic i_feat_wr,
  input wire logic [1:0] i_feat_entity,
  input wire logic [2:0] i_feat_sel,
  input wire logic [15:0] i_feat_data,
  input wire logic i_report_get,
  input wire logic [3:0] i_report_ep,
  input wire logic i_ctrl_byte,
  input wire logic i_ctrl_pkt_end,
  input wire logic i_desc_cfg_get,
  input wire logic o_ready,
  input wire logic [8:0] o_max_packet,
  input wire logic o_iso_accept,
  input wire logic o_fs_ok,
  input wire logic o_report_valid,
  input wire logic [3:0] o_report_ep,
  input wire logic [7:0] o_item_prefix,
  input wire logic o_ctrl_stall,
  input wire logic o_desc_skip_device,
  input wire logic o_req_stall,
  input wire logic [6:0] o_vol_l,
  input wire logic [6:0] o_vol_r
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] bcnt_reg, bcnt_next;
  logic [8:0] acnt_reg, acnt_next;
  // packet budget: bytes per sample times channels times 56
  function automatic logic [8:0] pkt_bytes(input logic [2:0] a);
    return (a == ALT_ZERO_BW) ? 9'h000 : 9'((int'(a) + 1) / 2 * (a[0] ? 1 : 2) * 56);
  endfunction : pkt_bytes
  // byte counters; control count saturates so a long packet cannot wrap below 9
  always_comb begin
    bcnt_next = bcnt_reg;
    if (i_ctrl_pkt_end) bcnt_next = 4'h0;
    else if (i_ctrl_byte && bcnt_reg != 4'hf) bcnt_next = bcnt_reg + 4'h1;
    acnt_next = i_sof ? 9'h000 : acnt_reg + {8'h00, o_iso_accept};
  end
  // counter registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_reg <= 4'h0;
      acnt_reg <= 9'h000;
    end else begin
      bcnt_reg <= bcnt_next;
      acnt_reg <= acnt_next;
    end
  end
  AST_PREFIX: assert property (o_item_prefix == 8'h00)
    else $error("item prefix not basic short");
  AST_VOL_RANGE: assert property ((o_vol_l <= VOL_MIN_DB || o_vol_l == VOL_MUTED)
    && (o_vol_r <= VOL_MIN_DB || o_vol_r == VOL_MUTED)) else $error("volume out of range");
  AST_VOL_CLAMP: assert property (i_feat_wr && i_feat_entity == ENT_FEATURE
    && i_feat_sel == FEAT_VOL_L && !i_feat_data[15] |-> ##4 o_vol_l == 7'h00)
    else $error("positive volume not clamped");
  AST_VOL_STEP: assert property (i_feat_wr && i_feat_entity == ENT_FEATURE
    && i_feat_sel == FEAT_VOL_R && i_feat_data[15:8] >= 8'hc4
    |-> ##4 o_vol_r == 7'(8'h00 - $past(i_feat_data[15:8], 4))) else $error("volume step");
  AST_VOL_MUTE: assert property (i_feat_wr && i_feat_entity == ENT_FEATURE
    && i_feat_sel == FEAT_VOL_L && i_feat_data[15] && i_feat_data[15:8] < 8'hc4
    |-> ##4 o_vol_l == VOL_MUTED) else $error("low volume not muted");
  AST_MAX_PKT: assert property (i_alt_wr && i_alt_setting <= ALT_MAX
    |-> ##3 o_max_packet == pkt_bytes($past(i_alt_setting, 3))) else $error("packet size");
  AST_ISO_CAP: assert property (o_iso_accept
    |-> acnt_reg < o_max_packet && acnt_reg < ISO_BUF_BYTES) else $error("iso overrun");
  AST_FS_OK: assert property ($past(i_rst_n) |-> o_fs_ok ==
    ($past(i_fs_hz) >= 24'(FS_MIN_HZ) && $past(i_fs_hz) <= 24'(FS_MAX_HZ)))
    else $error("rate window");
  AST_TERM_STALL: assert property (i_feat_wr && i_feat_entity != ENT_FEATURE
    && o_ready |=> o_req_stall) else $error("terminal request accepted");
  AST_REPORT_EP0: assert property (i_report_get && i_report_ep == EP_CONTROL
    && o_ready |=> o_report_valid && o_report_ep == EP_CONTROL) else $error("get report");
  AST_CTRL_STALL: assert property (i_ctrl_byte && !i_ctrl_pkt_end
    && bcnt_reg == 4'h8 |=> o_ctrl_stall) else $error("ninth byte not refused");
  AST_CTRL_OK: assert property ($rose(o_ctrl_stall) |-> bcnt_reg >= 4'h9)
    else $error("early control stall");
  AST_DESC: assert property (i_desc_cfg_get && o_ready |=> o_desc_skip_device)
    else $error("device descriptor not skipped");
  COV_STALL: cover property (o_ctrl_stall);
  COV_ISO: cover property (o_iso_accept);
  COV_STATUS: cover property (o_report_valid && o_report_ep == EP_STATUS);
endmodule : uafc_top_asserts

bind uafc_top uafc_top_asserts i_uafc_top_asserts (.*);

// >>> dv/testbench.sv
// self-checking bench for the feature control core
`timescale 1ns/1ps
module testbench;
  import uafc_pkg::*;
  typedef struct packed {logic [2:0] s; logic [15:0] d; logic [7:0] e;} uafc_row_s;
  logic i_sys_clk, i_rst_n, i_config_select_hi, i_config_select_lo, i_eeprom_valid;
  logic i_alt_wr, i_iso_byte, i_sof, i_feat_wr, i_report_get, i_report_set;
  logic i_ctrl_byte, i_ctrl_pkt_end, i_desc_cfg_get;
  logic [15:0] i_eeprom_word, i_feat_data;
  logic [23:0] i_fs_hz;
  logic [2:0] i_alt_setting, i_feat_sel, i_button;
  logic [1:0] i_feat_entity, i_report_out, i_button_role, o_map_sel, o_tone_mode, o_lamp;
  logic [3:0] i_report_ep, o_report_ep;
  logic o_ready, o_iso_accept, o_fs_ok, o_report_valid, o_ctrl_stall, o_desc_skip_device;
  logic o_req_stall, o_mute, o_boost;
  logic [8:0] o_max_packet;
  logic [7:0] o_report_data, o_item_prefix, o_treble, o_bass, st_data, st_cnt;
  logic [6:0] o_vol_l, o_vol_r;
  int miscompares = 0;
  int check_count = 0;
  int acc;
  uafc_row_s rows [12] = '{'{3'h0, 16'h0000, 8'h00}, '{3'h0, 16'h7fff, 8'h00},
    '{3'h0, 16'hffff, 8'h01}, '{3'h1, 16'hc400, 8'h3c}, '{3'h1, 16'hc3ff, 8'h7f},
    '{3'h0, 16'h8000, 8'h7f}, '{3'h1, 16'hf600, 8'h0a}, '{3'h2, 16'h0001, 8'h01},
    '{3'h3, 16'h0004, 8'h04}, '{3'h4, 16'h0085, 8'h00}, '{3'h4, 16'h0006, 8'h06},
    '{3'h5, 16'h0001, 8'h01}};
  uafc_top i_uafc_top (.*);
  uafc_host_model i_uafc_host_model (.i_sys_clk, .i_rst_n, .i_report_valid(o_report_valid),
    .i_report_ep(o_report_ep), .i_report_data(o_report_data), .o_status_data(st_data),
    .o_status_cnt(st_cnt));
  // 200 mhz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // accepted iso bytes, counted by the bench rather than trusted from the design
  always @(posedge i_sys_clk) if (o_iso_accept === 1'b1) acc++;
  task automatic tk(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tk
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic reset_dut(input logic hi, input logic lo);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    i_config_select_hi <= hi;
    i_config_select_lo <= lo;
    tk(10);
    i_rst_n <= 1'b1;
    tk(6);
    #1;
  endtask : reset_dut
  task automatic feat(input logic [1:0] e, input logic [2:0] s, input logic [15:0] d);
    @(posedge i_sys_clk);
    {i_feat_wr, i_feat_entity, i_feat_sel, i_feat_data} <= {1'b1, e, s, d};
    @(posedge i_sys_clk);
    i_feat_wr <= 1'b0;
  endtask : feat
  task automatic wait_rep(input int lim);
    int n;
    n = 0;
    #1;
    while (o_report_valid !== 1'b1) begin
      if (n == lim) begin
        miscompares++;
        stop_test();
      end
      @(posedge i_sys_clk);
      #1;
      n++;
    end
  endtask : wait_rep
  task automatic iso_burst(input int n, input logic [15:0] exp);
    @(posedge i_sys_clk);
    i_sof <= 1'b1;
    @(posedge i_sys_clk);
    {i_sof, i_iso_byte} <= 2'b01;
    acc = 0;
    tk(n);
    i_iso_byte <= 1'b0;
    tk(3);
    #1 check(16'(acc), exp);
  endtask : iso_burst
  task automatic alt(input logic [2:0] a);
    @(posedge i_sys_clk);
    {i_alt_wr, i_alt_setting} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_alt_wr <= 1'b0;
    tk(4);
  endtask : alt
  task automatic ctrl_pkt(input int n, input logic exp);
    @(posedge i_sys_clk);
    i_ctrl_byte <= 1'b1;
    tk(n);
    i_ctrl_byte <= 1'b0;
    tk(1);
    #1 check(o_ctrl_stall, exp);
    @(posedge i_sys_clk);
    i_ctrl_pkt_end <= 1'b1;
    @(posedge i_sys_clk);
    i_ctrl_pkt_end <= 1'b0;
    tk(1);
    #1 check(o_ctrl_stall, 1'b0);
  endtask : ctrl_pkt
  function automatic logic [7:0] feat_out(input logic [2:0] s);
    case (s)
      FEAT_VOL_L: return {1'b0, o_vol_l};
      FEAT_VOL_R: return {1'b0, o_vol_r};
      FEAT_MUTE: return {7'h00, o_mute};
      FEAT_TREBLE: return o_treble;
      FEAT_BASS: return o_bass;
      default: return {7'h00, o_boost};
    endcase
  endfunction : feat_out
  // cuts a hang short
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    {i_rst_n, i_eeprom_valid, i_alt_wr, i_iso_byte, i_sof, i_feat_wr, i_report_get} = 7'h00;
    {i_report_set, i_ctrl_byte, i_ctrl_pkt_end, i_desc_cfg_get} = 4'h0;
    {i_eeprom_word, i_feat_data, i_fs_hz} = 56'h0;
    {i_alt_setting, i_feat_sel, i_button, i_feat_entity, i_report_out} = 13'h0;
    {i_button_role, i_report_ep} = 6'h0;
    reset_dut(1'b1, 1'b0);
    check({o_ready, o_map_sel, o_tone_mode}, 16'h001a);
    check({o_vol_l, o_vol_r}, {7'h14, 7'h14});
    @(posedge i_sys_clk) i_button <= 3'b100;
    wait_rep(50);
    check({o_report_ep, o_report_data}, {EP_STATUS, 8'h04});
    tk(2);
    #1 check({st_cnt, st_data}, 16'h0104);
    @(posedge i_sys_clk);
    {i_report_set, i_report_ep, i_report_out} <= {1'b1, EP_CONTROL, 2'b10};
    @(posedge i_sys_clk);
    {i_report_set, i_report_get} <= 2'b01;
    @(posedge i_sys_clk);
    i_report_get <= 1'b0;
    wait_rep(5);
    check({o_report_ep, o_report_data}, {EP_CONTROL, 8'h14});
    check(o_lamp, 2'b10);
    foreach (rows[k]) begin
      feat(ENT_FEATURE, rows[k].s, rows[k].d);
      tk(4);
      #1 check(feat_out(rows[k].s), rows[k].e);
    end
    check(o_vol_l, 7'h7f);
    for (int e = 1; e < 3; e++) begin
      feat(2'(e), FEAT_MUTE, 16'h0000);
      #1 check(o_req_stall, 1'b1);
      tk(3);
      #1 check(o_mute, 1'b1);
    end
    feat(ENT_FEATURE, FEAT_VOL_L, 16'h0000);
    tk(4);
    {i_button_role, i_button} <= {2'd3, 3'b101};
    tk(3);
    #1 check(o_vol_l, 7'h01);
    @(posedge i_sys_clk) {i_button_role, i_button} <= {2'd2, 3'b100};
    tk(2);
    i_button <= 3'b101;
    tk(3);
    #1 check(o_vol_l, 7'h00);
    @(posedge i_sys_clk);
    {i_eeprom_valid, i_eeprom_word} <= {1'b1, 16'h0017};
    @(posedge i_sys_clk);
    i_eeprom_valid <= 1'b0;
    tk(4);
    #1 check({o_vol_l, o_vol_r, o_tone_mode}, {7'h05, 7'h05, 2'h3});
    for (int a = 0; a < ALT_COUNT; a++) begin
      alt(3'(a));
      #1 check(o_max_packet, 16'((a + 1) / 2 * (a % 2 ? 1 : 2) * 56 * (a > 0)));
    end
    alt(3'h7);
    #1 check(o_max_packet, 9'h150);
    @(posedge i_sys_clk) i_fs_hz <= 24'd48000;
    alt(3'h1);
    iso_burst(60, 16'd56);
    alt(3'h6);
    iso_burst(340, 16'd336);
    @(posedge i_sys_clk) i_fs_hz <= 24'd4999;
    iso_burst(10, 16'd0);
    #1 check(o_fs_ok, 1'b0);
    @(posedge i_sys_clk) i_fs_hz <= 24'd55000;
    tk(3);
    #1 check(o_fs_ok, 1'b1);
    ctrl_pkt(8, 1'b0);
    ctrl_pkt(9, 1'b1);
    check({o_desc_skip_device, o_item_prefix}, 16'h0000);
    @(posedge i_sys_clk);
    i_desc_cfg_get <= 1'b1;
    @(posedge i_sys_clk);
    i_desc_cfg_get <= 1'b0;
    tk(1);
    #1 check(o_desc_skip_device, 1'b1);
    reset_dut(1'b1, 1'b1);
    check({o_map_sel, o_tone_mode, o_lamp, o_desc_skip_device}, 16'h0060);
    check(o_vol_l, 7'h1e);
    stop_test();
  end
endmodule : testbench
